// >>> include/asp_cfg.svh
`ifndef ASP_CFG_SVH
`define ASP_CFG_SVH
// frame layout
`define ASP_FRAME_BITS 16
`define ASP_LEAD_ZEROS 4
`define ASP_RESULT_BITS 12
`define ASP_CNT_W 5
// power-down entry window on falling edge count
`define ASP_PD_LO 4
`define ASP_PD_HI 11
// power-up time in ns, host clock in MHz
`define ASP_PWRUP_NS 4330
`define ASP_CLK_MHZ 50
`define ASP_PWRUP_CYC ((`ASP_PWRUP_NS * `ASP_CLK_MHZ + 999) / 1000)
// quiet time in ns (plain default)
`define ASP_QUIET_NS 100
`define ASP_QUIET_CYC ((`ASP_QUIET_NS * `ASP_CLK_MHZ + 999) / 1000)
// autonomous conversion wait
`define ASP_CONV_NS 3300
`define ASP_CONV_CYC ((`ASP_CONV_NS * `ASP_CLK_MHZ + 999) / 1000)
// host serial clock divider half period, 50/(2*2)=12.5 MHz below 15 MHz
`define ASP_SCLK_HALF 2
// internal oscillator conversion length in link clocks
`define ASP_AUTO_CONV 40
`endif

// >>> include/asp_pkg.sv
package asp_pkg;
    typedef logic [11:0] asp_result_t;
    typedef logic [4:0] asp_cnt_t;
    typedef enum logic {ASP_AUTO, ASP_CLOCKED} asp_mode_e;
    typedef enum logic [1:0] {ASP_CMD_READ, ASP_CMD_PDOWN, ASP_CMD_WAKE, ASP_CMD_AUTO} asp_cmd_e;
endpackage

// >>> include/asp_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface asp_link_if;
    logic cs_n;
    logic sclk;
    logic convert_start_n;
    logic sdo;
    logic sdo_oe;
    modport dev (input cs_n, input sclk, input convert_start_n, output sdo, output sdo_oe);
    modport host (output cs_n, output sclk, output convert_start_n, input sdo, input sdo_oe);
endinterface
`default_nettype wire

// >>> verilog/asp_sync2.sv
`timescale 1ns/1ns
`default_nettype none
module asp_sync2 (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic d,
    output logic q
);
    logic meta;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= 1'b0;
            q <= 1'b0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // asp_sync2
`default_nettype wire

// >>> verilog/asp_adc_dev.sv
`timescale 1ns/1ns
`default_nettype none
`include "asp_cfg.svh"
module asp_adc_dev (
    input wire logic clk_link,
    input wire logic arst_n,
    asp_link_if.dev link,
    input wire asp_pkg::asp_result_t sample,
    output logic analog_on,
    output logic clocked_mode
);
    import asp_pkg::*;
    asp_cnt_t fall_cnt;
    logic fresh;
    logic powered;
    logic next_powered;
    logic [15:0] word;
    logic [15:0] shreg;
    asp_mode_e mode;
    assign word = {4'h0, sample};
    // new frame flag; sclk is gated, so select acts asynchronously
    always_ff @(negedge clk_link or posedge link.cs_n or negedge arst_n) begin
        if (!arst_n || link.cs_n) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end
    // falls counted from select, held after rise
    always_ff @(negedge clk_link or negedge arst_n) begin
        if (!arst_n) begin
            fall_cnt <= '0;
        end else if (fresh) begin
            fall_cnt <= 5'd1;
        end else if (fall_cnt != 5'(`ASP_FRAME_BITS)) begin
            fall_cnt <= fall_cnt + 5'd1;
        end
    end
    // sclk while convert low selects clocked
    always_ff @(posedge clk_link or negedge arst_n) begin
        if (!arst_n) begin
            mode <= ASP_AUTO;
        end else if (!link.convert_start_n) begin
            mode <= ASP_CLOCKED;
        end
    end
    always_comb begin
        next_powered = powered;
        if (mode == ASP_CLOCKED && fall_cnt >= 5'(`ASP_PD_LO) && fall_cnt < 5'(`ASP_PD_HI)) begin
            next_powered = 1'b0;
        end else if (fall_cnt >= 5'(`ASP_PD_HI)) begin
            next_powered = 1'b1;
        end
        // short attempts keep the old state
    end
    // count is stable here: sclk has stopped before select rises
    always_ff @(posedge link.cs_n or negedge arst_n) begin
        if (!arst_n) begin
            powered <= 1'b1;
        end else begin
            powered <= next_powered;
        end
    end
    always_ff @(posedge link.cs_n or negedge arst_n or negedge link.cs_n) begin
        if (!arst_n || !link.cs_n) begin
            analog_on <= 1'b1;
        end else begin
            analog_on <= next_powered;
        end
    end
    always_ff @(posedge clk_link or negedge arst_n) begin
        if (!arst_n) begin
            clocked_mode <= 1'b0;
        end else begin
            clocked_mode <= (mode == ASP_CLOCKED);
        end
    end
    always_ff @(negedge clk_link or negedge arst_n) begin
        if (!arst_n) begin
            shreg <= '0;
        end else if (fresh) begin
            shreg <= {word[13:0], 2'b00};
        end else begin
            shreg <= {shreg[14:0], 1'b0};
        end
    end
    // release at rise or 16th fall
    always_ff @(negedge clk_link or posedge link.cs_n or negedge arst_n) begin
        if (!arst_n || link.cs_n) begin
            link.sdo_oe <= 1'b0;
            link.sdo <= 1'b0;
        end else if (fresh) begin
            link.sdo_oe <= powered;
            link.sdo <= powered & word[14];
        end else begin
            link.sdo_oe <= powered && fall_cnt < 5'(`ASP_FRAME_BITS - 1);
            link.sdo <= powered && fall_cnt < 5'(`ASP_FRAME_BITS - 1) && shreg[15];
        end
    end
endmodule // asp_adc_dev
`default_nettype wire

// >>> verilog/asp_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "asp_cfg.svh"
module asp_host (
    input wire logic clk_sys,
    input wire logic arst_n,
    asp_link_if.host link,
    input wire logic cmd_valid,
    input wire asp_pkg::asp_cmd_e cmd,
    output logic cmd_ready,
    output logic data_valid,
    output asp_pkg::asp_result_t data
);
    import asp_pkg::*;
    typedef enum logic [2:0] {H_IDLE, H_CONV, H_FRAME, H_QUIET} asp_hstate_e;
    asp_hstate_e st;
    asp_cmd_e cur;
    logic [7:0] wait_cnt;
    logic [1:0] div;
    asp_cnt_t edges;
    logic [15:0] rx;
    logic sdo_s;
    asp_sync2 u_sync (.clk(clk_sys), .arst_n(arst_n), .d(link.sdo), .q(sdo_s));
    function automatic asp_cnt_t frame_len(input asp_cmd_e c);
        // 8-clock burst for power-down, full frame otherwise
        frame_len = (c == ASP_CMD_PDOWN) ? 5'd8 : 5'(`ASP_FRAME_BITS);
    endfunction
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st <= H_IDLE;
            cur <= ASP_CMD_READ;
            wait_cnt <= '0;
            div <= '0;
            edges <= '0;
            rx <= '0;
            link.cs_n <= 1'b1;
            link.sclk <= 1'b0;
            link.convert_start_n <= 1'b1;
            cmd_ready <= 1'b0;
            data_valid <= 1'b0;
            data <= '0;
        end else begin
            data_valid <= 1'b0;
            unique case (st)
                H_IDLE: begin
                    cmd_ready <= 1'b1;
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready <= 1'b0;
                        cur <= cmd;
                        edges <= '0;
                        div <= '0;
                        if (cmd == ASP_CMD_AUTO) begin
                            link.convert_start_n <= 1'b0;
                            wait_cnt <= 8'(`ASP_CONV_CYC);
                            st <= H_CONV;
                        end else begin
                            // convert held low so sclk selects clocked mode
                            link.convert_start_n <= 1'b0;
                            link.cs_n <= 1'b0;
                            st <= H_FRAME;
                        end
                    end
                end
                H_CONV: begin
                    if (wait_cnt != '0) begin
                        wait_cnt <= wait_cnt - 8'd1;
                    end else begin
                        link.convert_start_n <= 1'b1;
                        link.cs_n <= 1'b0;
                        st <= H_FRAME;
                    end
                end
                H_FRAME: begin
                    div <= div + 2'd1;
                    if (div == 2'(`ASP_SCLK_HALF - 1)) begin
                        div <= '0;
                        if (edges == frame_len(cur)) begin
                            link.cs_n <= 1'b1;
                            link.convert_start_n <= 1'b1;
                            wait_cnt <= 8'(`ASP_QUIET_CYC);
                            data <= rx[11:0];
                            data_valid <= (cur != ASP_CMD_PDOWN);
                            st <= H_QUIET;
                        end else if (link.sclk) begin
                            link.sclk <= 1'b0;
                            edges <= edges + 5'd1;
                            // msb first; synced bit stood through the high phase
                            rx <= {rx[14:0], sdo_s};
                        end else begin
                            link.sclk <= 1'b1;
                        end
                    end
                end
                H_QUIET: begin
                    if (wait_cnt != '0) begin
                        wait_cnt <= wait_cnt - 8'd1;
                    end else begin
                        st <= H_IDLE;
                    end
                end
                default: st <= H_IDLE;
            endcase
        end
    end
endmodule // asp_host
`default_nettype wire

// >>> tb/asp_link_sva.sv
`timescale 1ns/1ns
`default_nettype none
module asp_link_sva (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic convert_start_n,
    input wire logic sdo,
    input wire logic sdo_oe
);
    logic sclk_q;
    logic cs_q;
    logic [4:0] cnt;
    logic fall;
    logic [4:0] cnt_now;
    assign fall = sclk_q & ~sclk;
    // count restarts at every select, holds while idle
    assign cnt_now = (cs_q & ~cs_n) ? 5'h00 : cnt + {4'h0, fall};
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sclk_q <= 1'h0;
            cs_q <= 1'h1;
            cnt <= 5'h00;
        end else begin
            sclk_q <= sclk;
            cs_q <= cs_n;
            cnt <= cnt_now;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence s_hi2;
        sclk ##1 sclk ##1 !sclk;
    endsequence
    sequence s_lo2;
        !sclk ##1 !sclk;
    endsequence
    property p_idle_low; cs_n |-> !sclk; endproperty
    a_idle_low: assert property (p_idle_low) else $error("sclk high while deselected");
    property p_hi; $rose(sclk) |-> s_hi2; endproperty
    a_hi: assert property (p_hi) else $error("sclk high phase wrong");
    property p_lo; $fell(sclk) && !cs_n |-> s_lo2; endproperty
    a_lo: assert property (p_lo) else $error("sclk low phase wrong");
    property p_zeros; !cs_n && sdo_oe && cnt_now < 5'h04 |-> !sdo; endproperty
    a_zeros: assert property (p_zeros) else $error("leading bit not zero");
    property p_frame; $rose(cs_n) |-> cnt_now == 5'h10 || cnt_now == 5'h08; endproperty
    a_frame: assert property (p_frame) else $error("frame edge count wrong");
    property p_oe_end; fall && cnt_now == 5'h10 |-> ##[0:2] !sdo_oe; endproperty
    a_oe_end: assert property (p_oe_end) else $error("output kept after 16th fall");
    property p_quiet; $rose(cs_n) |-> cs_n [*5]; endproperty
    a_quiet: assert property (p_quiet) else $error("quiet gap too short");
    property p_setup; $fell(cs_n) |-> !sclk; endproperty
    a_setup: assert property (p_setup) else $error("sclk high at select");
endmodule // asp_link_sva
`default_nettype wire

// >>> tb/adc_serial_powerdown_control_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module adc_serial_powerdown_control_tb_top;
    import asp_pkg::*;
    logic clk_sys = 1'h0;
    logic arst_n = 1'h0;
    logic cmd_valid = 1'h0;
    logic dv_seen = 1'h0;
    asp_cmd_e cmd = ASP_CMD_READ;
    logic cmd_ready, data_valid, analog_on, clocked_mode;
    asp_result_t data;
    asp_result_t sample = 12'h000;
    logic [15:0] frame = 16'h0000;
    logic sclk_p = 1'h0;
    int n_fail = 0;
    int comparisons = 0;
    asp_link_if link();
    asp_host u_asp_host(.clk_sys(clk_sys), .arst_n(arst_n), .link(link), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_ready(cmd_ready), .data_valid(data_valid), .data(data));
    asp_adc_dev u_asp_adc_dev(.clk_link(link.sclk), .arst_n(arst_n), .link(link),
        .sample(sample), .analog_on(analog_on), .clocked_mode(clocked_mode));
    asp_link_sva u_asp_link_sva(.clk_sys(clk_sys), .arst_n(arst_n), .cs_n(link.cs_n),
        .sclk(link.sclk), .convert_start_n(link.convert_start_n), .sdo(link.sdo),
        .sdo_oe(link.sdo_oe));
    initial forever #10 clk_sys = ~clk_sys;
    // bit read just after a rise is the one standing through the high phase
    always @(negedge clk_sys) begin
        sclk_p <= link.sclk;
        if (!sclk_p && link.sclk && !link.cs_n) frame <= {frame[14:0], link.sdo};
    end
    always @(posedge clk_sys) if (data_valid === 1'h1) dv_seen <= 1'h1;
    function automatic logic [15:0] exp_frame(asp_result_t s);
        return {4'h0, s};
    endfunction
    task automatic check16(string name, logic [15:0] e, logic [15:0] s);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", name, e, s);
        end
    endtask
    task automatic check1(string name, logic e, logic s);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected %s expected %b seen %b", name, e, s);
        end
    endtask
    task automatic run(asp_cmd_e c);
        int i;
        @(negedge clk_sys);
        cmd = c;
        cmd_valid = 1'h1;
        dv_seen = 1'h0;
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
        end while (cmd_ready !== 1'h1 && i < 100);
        @(negedge clk_sys);
        cmd_valid = 1'h0;
        i = 0;
        repeat (3) @(negedge clk_sys);
        while (cmd_ready !== 1'h1 && i < 2000) begin
            @(negedge clk_sys);
            i++;
        end
        check1("cmd_ready", 1'h1, cmd_ready);
        repeat (10) @(negedge clk_sys);
    endtask
    task automatic read_chk(asp_cmd_e c);
        run(c);
        check1("data_valid", 1'h1, dv_seen);
        check16("data", exp_frame(sample), {4'h0, data});
        check16("frame", exp_frame(sample), frame);
    endtask
    task automatic summarize;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h1441));
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        arst_n = 1'h1;
        check1("clocked_mode", 1'h0, clocked_mode);
        check1("sdo_oe", 1'h0, link.sdo_oe);
        run(ASP_CMD_READ);
        check1("clocked_mode", 1'h1, clocked_mode);
        // host masters a gated, selected clock
        // extremes first, then random words, both read kinds
        for (int k = 0; k < 6; k++) begin
            sample = (k == 0) ? 12'hFFF : (k == 1) ? 12'h000 : 12'($urandom);
            read_chk((k % 3 == 2) ? ASP_CMD_AUTO : ASP_CMD_READ);
        end
        run(ASP_CMD_READ);
        run(ASP_CMD_PDOWN);
        check1("analog_on", 1'h0, analog_on);
        check1("sdo_oe", 1'h0, link.sdo_oe);
        run(ASP_CMD_PDOWN);
        check1("analog_on", 1'h0, analog_on);
        run(ASP_CMD_WAKE);
        check1("analog_on", 1'h1, analog_on);
        sample = 12'($urandom);
        read_chk(ASP_CMD_READ);
        summarize();
    end
    initial begin
        #(20 * 20000);
        n_fail++;
        summarize();
    end
endmodule // adc_serial_powerdown_control_tb_top
`default_nettype wire
